// ==== common/qsm_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef QSM_MAP_SVH
`define QSM_MAP_SVH
`define QSM_CTRL1 8'h00
`define QSM_CTRL2 8'h04
`define QSM_STATUS 8'h08
`define QSM_CLEAR 8'h0C
`define QSM_INT_EN 8'h10
`define QSM_PORT_DATA 8'h14
`define QSM_PORT_DIR 8'h18
`define QSM_PIN_ASSIGN 8'h1C
`define QSM_TXQ_BASE 2'h1
`define QSM_RXQ_BASE 2'h2
`define QSM_EN_BIT 0
`define QSM_EV_FINISH 0
`define QSM_EV_XFER 1
`define QSM_PIN_MISO 0
`define QSM_PIN_MOSI 1
`define QSM_PIN_SCK 2
`define QSM_PIN_SEL0 3
`define QSM_PORT_RST 7'h00
`define QSM_CLK_NS 4
`define QSM_SCK_NS 32
`define QSM_HALF ((`QSM_SCK_NS / 2) / `QSM_CLK_NS)
`endif

// ==== common/qsm_pkg.sv ====
// Types shared by the queued serial master
package qsm_pkg;
   // Engine states, Gray coded along the transfer path
   typedef enum logic [1:0] {
      QSM_IDLE = 2'b00,
      QSM_LOAD = 2'b01,
      QSM_SHIFT = 2'b11,
      QSM_NEXT = 2'b10
   } qsm_state_t;
   // Second control register layout
   typedef struct packed {
      logic irq_en;
      logic wrap_enable;
      logic [1:0] rsv1;
      logic [3:0] end_queue_pointer;
      logic [3:0] rsv0;
      logic [3:0] start_queue_pointer;
   } qsm_ctrl2_t;
   // One queue command word: select bits and data byte
   typedef struct packed {
      logic [3:0] sel;
      logic [7:0] data;
   } qsm_cmd_t;
endpackage

// ==== hw/qsm_master.sv ====
// Queued serial master with shared port pins and an AHB-Lite register slave
//
// Overview of operation
// - Frames follow SPI mode zero, MSB first
// - Sixteen-entry queue run automatically between pointers
// - Wrap restarts at start pointer indefinitely
// - Selects asserted while their command executes
// - Port data bit gives select inactive level
// - Port data read returns sampled pin levels
// - Assigned pins driven by engine during transfers
// - Idle pins revert to stored port data
// - Select one maps to port bit four
// - Finished flag interrupts when enabled
// - Wrap cleared: one pass then stop
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "qsm_map.svh"
module qsm_master
   import qsm_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Port pins: input, output, active-low output enable
   input wire logic [6:0] pin_i,
   output logic [6:0] pin_o,
   output logic [6:0] pin_oe_n_o,
   // Interrupt
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////////////
   // State declarations
   logic [6:0] pin_m; // First synchroniser stage
   logic [6:0] pin_s; // Synchronised pin levels
   logic [31:0] ctrl1; // Enable register
   qsm_ctrl2_t ctrl2; // Pointers, wrap and finish interrupt enable
   logic [1:0] status; // Sticky events
   logic [1:0] int_en; // Event enables
   logic [6:0] port_data; // Stored pin values
   logic [6:0] port_dir; // Pin directions, one is output
   logic [6:0] pin_assign; // One gives the pin to the engine
   qsm_cmd_t txq [16]; // Command and transmit queue
   logic [7:0] rxq [16]; // Receive queue
   logic wr_pend, next_wr_pend; // Write data phase pending
   logic [7:0] wr_addr, next_wr_addr; // Latched write address
   logic [31:0] next_hrdata;
   logic [31:0] next_ctrl1;
   qsm_ctrl2_t next_ctrl2;
   logic [1:0] next_status, next_int_en;
   logic [6:0] next_port_data, next_port_dir, next_pin_assign;
   logic next_irq;
   qsm_state_t state, next_state; // Engine state
   logic [7:0] div, next_div; // Half-period divider
   logic [2:0] bits, next_bits; // Bit counter
   logic [7:0] shift, next_shift; // Shift register
   logic rx_bit, next_rx_bit; // Bit caught on the rising edge
   logic [3:0] ptr, next_ptr; // Current queue pointer
   logic [3:0] sel, next_sel; // Selects of the current command
   logic sck, next_sck; // Serial clock level
   logic act, next_act; // Engine owns its pins
   logic en_q, next_en_q; // Enable seen last cycle
   logic [6:0] next_pin, next_oe_n;
   logic tick; // Divider enable pulse
   logic done_ev; // Queue finished event
   logic xfer_ev; // One transfer finished
   logic addr_ok; // Valid address phase

   ////////////////////////////////////////////////////////////////////////////
   // Address decode for the two queue windows
   function automatic logic in_q(input logic [7:0] a, input logic [1:0] base);
      in_q = (a[7:6] == base);
   endfunction

   // Divider enable: one pulse per half serial clock
   assign tick = (div == 8'(`QSM_HALF - 1));
   assign addr_ok = hsel_i & htrans_i[1] & hready_i;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave and register next values
   always_comb begin
      next_wr_pend = addr_ok & hwrite_i;
      next_wr_addr = addr_ok ? haddr_i : wr_addr;
      next_ctrl1 = ctrl1;
      next_ctrl2 = ctrl2;
      next_int_en = int_en;
      next_port_data = port_data;
      next_port_dir = port_dir;
      next_pin_assign = pin_assign;
      next_status = status;
      next_hrdata = hrdata_o;
      if (wr_pend) begin
         unique case (wr_addr)
            `QSM_CTRL1: next_ctrl1 = {31'h0, hwdata_i[`QSM_EN_BIT]};
            `QSM_CTRL2: next_ctrl2 = qsm_ctrl2_t'(hwdata_i[15:0] & 16'hCF0F);
            `QSM_CLEAR: next_status = status & ~hwdata_i[1:0];
            `QSM_INT_EN: next_int_en = hwdata_i[1:0];
            `QSM_PORT_DATA: next_port_data = hwdata_i[6:0];
            `QSM_PORT_DIR: next_port_dir = hwdata_i[6:0];
            `QSM_PIN_ASSIGN: next_pin_assign = hwdata_i[6:0];
            default: ; // Queue writes and unmapped addresses
         endcase
      end
      // Events set after the clear so a same-cycle event wins
      next_status = next_status | {xfer_ev, done_ev};
      if (addr_ok & ~hwrite_i) begin
         next_hrdata = 32'h0;
         if (in_q(haddr_i, `QSM_TXQ_BASE)) begin
            next_hrdata = {20'h0, txq[haddr_i[5:2]]};
         end else if (in_q(haddr_i, `QSM_RXQ_BASE)) begin
            next_hrdata = {24'h0, rxq[haddr_i[5:2]]};
         end else begin
            unique case (haddr_i)
               `QSM_CTRL1: next_hrdata = ctrl1;
               `QSM_CTRL2: next_hrdata = {16'h0, ctrl2};
               `QSM_STATUS: next_hrdata = {30'h0, status};
               `QSM_INT_EN: next_hrdata = {30'h0, int_en};
               `QSM_PORT_DATA: next_hrdata = {25'h0, pin_s};
               `QSM_PORT_DIR: next_hrdata = {25'h0, port_dir};
               `QSM_PIN_ASSIGN: next_hrdata = {25'h0, pin_assign};
               default: next_hrdata = 32'h0; // Unmapped reads as zero
            endcase
         end
      end
      // Finish event also needs the second control enable
      next_irq = |(next_status & int_en & {1'b1, ctrl2.irq_en});
   end

   // Bus slave registers and transmit queue writes
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata_o <= 32'h0;
         hreadyout_o <= 1'b0;
         hresp_o <= 1'b0;
         ctrl1 <= 32'h0;
         ctrl2 <= qsm_ctrl2_t'(16'h0000);
         status <= 2'h0;
         int_en <= 2'h0;
         port_data <= `QSM_PORT_RST;
         port_dir <= 7'h00;
         pin_assign <= 7'h00;
         irq_o <= 1'b0;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata_o <= next_hrdata;
         hreadyout_o <= 1'b1; // Zero wait states, always OKAY
         hresp_o <= 1'b0;
         ctrl1 <= next_ctrl1;
         ctrl2 <= next_ctrl2;
         status <= next_status;
         int_en <= next_int_en;
         port_data <= next_port_data;
         port_dir <= next_port_dir;
         pin_assign <= next_pin_assign;
         irq_o <= next_irq;
      end
      if (wr_pend & in_q(wr_addr, `QSM_TXQ_BASE)) begin
         txq[wr_addr[5:2]] <= qsm_cmd_t'(hwdata_i[11:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer engine next values
   always_comb begin
      next_state = state;
      next_div = (state == QSM_SHIFT && !tick) ? div + 8'h01 : 8'h00;
      next_bits = bits;
      next_shift = shift;
      next_rx_bit = rx_bit;
      next_ptr = ptr;
      next_sel = sel;
      next_sck = sck;
      next_act = act;
      next_en_q = ctrl1[`QSM_EN_BIT];
      done_ev = 1'b0;
      xfer_ev = 1'b0;
      unique case (state)
         QSM_IDLE: begin
            // A rising enable starts a run at the start pointer
            if (ctrl1[`QSM_EN_BIT] & ~en_q) begin
               next_ptr = ctrl2.start_queue_pointer;
               next_state = QSM_LOAD;
            end
         end
         QSM_LOAD: begin
            next_shift = txq[ptr].data;
            next_sel = txq[ptr].sel;
            next_bits = 3'h0;
            next_sck = 1'b0;
            next_act = 1'b1;
            next_state = QSM_SHIFT;
         end
         QSM_SHIFT: begin
            if (tick & ~sck) begin
               // Leading edge samples the input line
               next_sck = 1'b1;
               next_rx_bit = pin_s[`QSM_PIN_MISO];
            end else if (tick) begin
               // Trailing edge shifts the next bit out
               next_sck = 1'b0;
               next_shift = {shift[6:0], rx_bit};
               next_bits = bits + 3'h1;
               if (bits == 3'h7) begin
                  next_state = QSM_NEXT;
               end
            end
         end
         QSM_NEXT: begin
            xfer_ev = 1'b1;
            if (!ctrl1[`QSM_EN_BIT]) begin
               // Software disable ends the run at a byte boundary
               next_act = 1'b0;
               next_state = QSM_IDLE;
            end else if (ptr == ctrl2.end_queue_pointer) begin
               done_ev = 1'b1;
               if (ctrl2.wrap_enable) begin
                  next_ptr = ctrl2.start_queue_pointer;
                  next_state = QSM_LOAD;
               end else begin
                  next_act = 1'b0;
                  next_state = QSM_IDLE;
               end
            end else begin
               next_ptr = ptr + 4'h1;
               next_state = QSM_LOAD;
            end
         end
      endcase
   end

   // Transfer engine registers and receive queue writes
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state <= QSM_IDLE;
         div <= 8'h00;
         bits <= 3'h0;
         shift <= 8'h00;
         rx_bit <= 1'b0;
         ptr <= 4'h0;
         sel <= 4'h0;
         sck <= 1'b0;
         act <= 1'b0;
         en_q <= 1'b0;
      end else begin
         state <= next_state;
         div <= next_div;
         bits <= next_bits;
         shift <= next_shift;
         rx_bit <= next_rx_bit;
         ptr <= next_ptr;
         sel <= next_sel;
         sck <= next_sck;
         act <= next_act;
         en_q <= next_en_q;
      end
      if (state == QSM_NEXT) begin
         rxq[ptr] <= shift;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin multiplexer next values
   always_comb begin
      next_pin = port_data;
      next_oe_n = ~port_dir;
      if (act) begin
         for (int k = 0; k < 7; k++) begin
            if (pin_assign[k]) begin
               if (k == `QSM_PIN_MOSI) begin
                  next_pin[k] = shift[7];
               end else if (k == `QSM_PIN_SCK) begin
                  next_pin[k] = sck;
               end else if (k >= `QSM_PIN_SEL0) begin
                  // Select bit four is select one; stored bit is idle level
                  next_pin[k] = port_data[k] ^ sel[2'(k - `QSM_PIN_SEL0)];
               end
            end
         end
      end
   end

   // Pin synchroniser and pin output registers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pin_m <= 7'h00;
         pin_s <= 7'h00;
         pin_o <= `QSM_PORT_RST;
         pin_oe_n_o <= 7'h7F;
      end else begin
         pin_m <= pin_i;
         pin_s <= pin_m;
         pin_o <= next_pin;
         pin_oe_n_o <= next_oe_n;
      end
   end
endmodule // qsm_master

// ==== tb/qsm_checker.sv ====
// Port assertions for the queued serial master
`timescale 1ns/1ps
module qsm_checker (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Bus signals watched
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   // Pins and interrupt
   input wire logic [6:0] pin_o,
   input wire logic [6:0] pin_oe_n_o,
   input wire logic irq_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // SCK holds high four cycles then falls
   sequence s_high;
      pin_o[2] [*4] ##1 !pin_o[2];
   endsequence
   // SCK holds low at least four cycles
   sequence s_low;
      !pin_o[2] [*4];
   endsequence
   a_sck_high_time: assert property ($rose(pin_o[2]) |-> s_high)
      else $error("SCK high time wrong");
   a_sck_low_time: assert property ($fell(pin_o[2]) |-> s_low)
      else $error("SCK low time wrong");
   a_mosi_hold: assert property (pin_o[2] && $past(pin_o[2]) |-> $stable(pin_o[1]))
      else $error("MOSI moved while SCK high");
   a_sel_steady: assert property (pin_o[2] |-> $stable(pin_o[6:3]))
      else $error("Select moved inside a byte");
   a_rd_holds: assert property (!$past(hsel_i && htrans_i[1] && !hwrite_i && hready_i)
      |-> $stable(hrdata_o)) else $error("Read data changed without a read");
   a_ready_release: assert property ($fell(reset_i) |-> !hreadyout_o ##1 hreadyout_o)
      else $error("Ready timing after reset wrong");
   a_oe_reset: assert property ($fell(reset_i) |-> pin_oe_n_o == 7'h7F)
      else $error("Pins driven after reset");
   a_irq_reset: assert property ($fell(reset_i) |-> !irq_o [*2])
      else $error("Interrupt high after reset");
endmodule // qsm_checker
bind qsm_master qsm_checker chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .irq_o(irq_o));

// ==== tb/qsm_peer.sv ====
// Far-side serial peripheral: returns a reply byte and collects MOSI
`timescale 1ns/1ps
module qsm_peer (
   // Serial lines from the master
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic sel_n_i,
   // Reply byte and last byte received
   input wire logic [7:0] reply_i,
   output logic miso_o,
   output logic [7:0] got_o
);
   logic [7:0] sh = 8'hFF;
   logic [7:0] rx = 8'h00;
   int n = 0;
   initial miso_o = 1'b1;
   initial got_o = 8'h00;
   // New frame: first bit out before the first rising SCK
   always @(negedge sel_n_i) begin
      sh = reply_i;
      n = 0;
      miso_o = sh[7];
   end
   // Released line returns to its pull-up
   always @(posedge sel_n_i) miso_o = 1'b1;
   // Capture on rising SCK, MSB first
   always @(posedge sck_i) if (!sel_n_i) begin
      rx = {rx[6:0], mosi_i};
      n = (n + 1) % 8;
      if (n == 0) got_o = rx;
   end
   // Shift on falling SCK, reload between bytes
   always @(negedge sck_i) if (!sel_n_i) begin
      sh = (n == 0) ? reply_i : {sh[6:0], 1'b1};
      miso_o = sh[7];
   end
endmodule // qsm_peer

// ==== tb/queued_serial_master_pin_control_test.sv ====
// Self-checking bench for the queued serial master
`timescale 1ns/1ps
`include "qsm_map.svh"
`define CMP(e, a) begin comparisons++; if ((e) !== (a)) begin error_cnt++; \
   $display("ERROR t=%0t exp=%h got=%h", $time, e, a); end end
module queued_serial_master_pin_control_test;
   import qsm_pkg::*;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, hready, hresp, rsp, irq, miso, sck_d = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [7:0] haddr = 8'h00, reply = 8'h00, peer_got;
   logic [31:0] hwdata = 32'h0, hrdata, rdv, ev, av, seed = 32'h00013C45;
   logic [6:0] pin_o, oe_n, pin_i, ext = 7'h00;
   logic [7:0] tx [4];
   logic [31:0] exp_q [$], act_q [$];
   int error_cnt = 0, comparisons = 0, pulses = 0, p0, i;
   initial forever #2 ref_clk_i = ~ref_clk_i;
   // Wire level: driven pins loop back, MISO from peer, rest from outside
   assign pin_i = (~oe_n & pin_o) | (oe_n & {ext[6:1], miso});
   qsm_master uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_n_o(oe_n), .irq_o(irq));
   qsm_peer peer (.sck_i(pin_o[2]), .mosi_i(pin_o[1]), .sel_n_i(pin_o[4]), .reply_i(reply),
      .miso_o(miso), .got_o(peer_got));
   // Count rising SCK edges
   always @(posedge ref_clk_i) begin
      sck_d <= pin_o[2];
      if (pin_o[2] && !sck_d) pulses <= pulses + 1;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // One single AHB-Lite transfer; read data taken at the data phase edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      rdv = hrdata;
      rsp = hresp;
      // Idle gap lets pin levels settle before a reread
      repeat (2) @(posedge ref_clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   // Note an expectation and hand the observed value to the monitor
   task automatic ck(input logic [31:0] e, input logic [31:0] a);
      exp_q.push_back(e);
      act_q.push_back(a);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      ck(e, rdv);
      ck(32'h0, {31'h0, rsp});
   endtask
   task automatic conclude();
      // Let the monitor finish the notes still queued
      wait (act_q.size() == 0);
      @(posedge ref_clk_i);
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Monitor: oldest expectation against oldest observation
   initial forever begin
      wait (act_q.size() > 0);
      ev = exp_q.pop_front();
      av = act_q.pop_front();
      `CMP(ev, av)
   end
   initial begin
      #40000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      ck(32'h7F, {25'h0, oe_n});
      // Configure first, enable last
      wr(`QSM_PORT_DATA, 32'h78);
      wr(`QSM_PORT_DIR, 32'h3E);
      wr(`QSM_PIN_ASSIGN, 32'h3E);
      for (i = 0; i < 4; i++) begin
         seed = xs(seed);
         tx[i] = seed[7:0];
         wr(8'(8'h40 + ((14 + i) % 16) * 4), {20'h0, 4'h2, tx[i]});
      end
      reply <= seed[15:8];
      ext <= seed[22:16];
      wr(`QSM_CTRL2, 32'h0000810E);
      wr(`QSM_INT_EN, 32'h1);
      wr(`QSM_CLEAR, 32'h3);
      p0 = pulses;
      wr(`QSM_CTRL1, 32'h1);
      for (i = 0; i < 2000 && pin_o[4] !== 1'b0; i++) @(posedge ref_clk_i);
      ck(32'h5, {29'h0, pin_o[5:3]});
      ck(32'h0, {30'h0, oe_n[2:1]});
      for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge ref_clk_i);
      ck(32'h1, {31'h0, irq});
      repeat (64) @(posedge ref_clk_i);
      ck(32'h20, 32'(pulses - p0));
      ck(32'h7, {29'h0, pin_o[5:3]});
      for (i = 0; i < 4; i++) rd(8'(8'h80 + ((14 + i) % 16) * 4), {24'h0, reply});
      ck({24'h0, tx[3]}, {24'h0, peer_got});
      rd(`QSM_STATUS, 32'h3);
      // Mask, unmask, clear
      wr(`QSM_INT_EN, 32'h0);
      ck(32'h0, {31'h0, irq});
      wr(`QSM_INT_EN, 32'h1);
      ck(32'h1, {31'h0, irq});
      // Transfer-done event alone also raises the line
      wr(`QSM_INT_EN, 32'h2);
      ck(32'h1, {31'h0, irq});
      wr(`QSM_CLEAR, 32'h3);
      ck(32'h0, {31'h0, irq});
      // Port data reads back pin levels; change it only while disabled
      wr(`QSM_CTRL1, 32'h0);
      wr(`QSM_PORT_DATA, 32'h18);
      rd(`QSM_PORT_DATA, {25'h0, ext[6], 6'h19});
      rd(8'h3C, 32'h0);
      // Single entry with wrap keeps running
      wr(8'h54, 32'h000002A5);
      wr(`QSM_CTRL2, 32'h00004505);
      wr(`QSM_INT_EN, 32'h1);
      p0 = pulses;
      wr(`QSM_CTRL1, 32'h1);
      repeat (600) @(posedge ref_clk_i);
      ck(32'h1, {31'h0, (pulses - p0) > 16});
      // Finish flag is set but the second control enable is off
      ck(32'h0, {31'h0, irq});
      wr(`QSM_CTRL1, 32'h0);
      repeat (100) @(posedge ref_clk_i);
      ck(32'h1, {31'h0, pin_o[4]});
      conclude();
   end
endmodule // queued_serial_master_pin_control_test
